// ---- core/phy_regs_pkg.sv ----
// Purpose: shared constants for the port status / cable diagnostic register bank
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   byte address = bank base + 4 * register index
package phy_regs_pkg;
   // ==========================================================
   // address map
   localparam int unsigned BANK_LSB = 6;
   localparam int unsigned IDX_LSB = 2;
   localparam logic [1:0] BANK_PORT1 = 2'h0;
   localparam logic [1:0] BANK_PORT2 = 2'h1;
   localparam logic [1:0] BANK_PHY2 = 2'h2;
   localparam logic [1:0] BANK_IRQ = 2'h3;
   localparam logic [3:0] IDX_P1_LINK_STATUS = 4'h4;
   localparam logic [3:0] IDX_P2_CONTROL_ONE = 4'h0;
   localparam logic [3:0] IDX_P2_CONTROL_TWO = 4'h2;
   localparam logic [3:0] IDX_P2_VLAN_ID_CONTROL = 4'h4;
   localparam logic [3:0] IDX_P2_CONTROL_THREE = 4'h6;
   localparam logic [3:0] IDX_P2_INGRESS_RATE = 4'h8;
   localparam logic [3:0] IDX_P2_EGRESS_RATE = 4'ha;
   localparam logic [3:0] IDX_P2_SPECIAL = 4'h0;
   localparam logic [3:0] IDX_IRQ_STATUS = 4'h0;
   localparam logic [3:0] IDX_IRQ_MASK = 4'h1;
   // ==========================================================
   // field positions
   localparam int unsigned LS_XOVER = 15;
   localparam int unsigned LS_POL = 13;
   localparam int unsigned LS_RXFC = 12;
   localparam int unsigned LS_TXFC = 11;
   localparam int unsigned LS_SPEED = 10;
   localparam int unsigned LS_DUPLEX = 9;
   localparam int unsigned LS_MDI = 7;
   localparam int unsigned LS_AN_DONE = 6;
   localparam int unsigned LS_LINK = 5;
   localparam int unsigned LS_PARTNER_LSB = 0;
   localparam int unsigned SP_SHORT = 15;
   localparam int unsigned SP_RESULT_LSB = 13;
   localparam int unsigned SP_DIAG_EN = 12;
   localparam int unsigned SP_FORCE = 11;
   localparam int unsigned SP_PWR = 10;
   localparam int unsigned SP_LOOP = 9;
   localparam int unsigned SP_COUNT_LSB = 0;
   localparam int unsigned IRQ_DIAG = 0;
   localparam int unsigned IRQ_LINK = 1;
   localparam int unsigned IRQ_MODE = 2;
   localparam int unsigned IRQ_W = 3;
   // ==========================================================
   // widths, depths, reset values
   localparam int unsigned WORD_W = 16;
   localparam int unsigned MEM_DEPTH = 6;
   localparam int unsigned MEM_AW = 3;
   localparam int unsigned SYNC_W = 26;
   localparam logic XOVER_RST = 1'b1;
   localparam logic PWR_RST = 1'b1;
   localparam logic [15:0] P2_WORD_RST = 16'h0000;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   typedef enum logic [0:0] {BUS_IDLE, BUS_WAIT} bus_state_type;
endpackage : phy_regs_pkg

// ---- core/word_store.sv ----
// Purpose: small word store for the second port's switch control words
// Assumes: one write and one read port, same clock
// Notes:   read data is registered, so it lags the read address by one edge
module word_store
   import phy_regs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [MEM_AW-1:0] wr_addr_i,
   input wire logic [WORD_W-1:0] wr_data_i,
   input wire logic [MEM_AW-1:0] rd_addr_i,
   output logic [WORD_W-1:0] rd_data_o
);
   logic [WORD_W-1:0] mem_r [MEM_DEPTH];

   // ==========================================================
   // storage: one process per entry
   for (genvar e = 0; e < MEM_DEPTH; e++) begin : g_entry
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            mem_r[e] <= P2_WORD_RST;
         end else if (wr_en_i && wr_addr_i == MEM_AW'(e)) begin
            mem_r[e] <= wr_data_i;
         end
      end
   end

   // ==========================================================
   // registered read; out-of-range address reads zero
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rd_data_o <= P2_WORD_RST;
      end else if (rd_addr_i < MEM_AW'(MEM_DEPTH)) begin
         rd_data_o <= mem_r[rd_addr_i];
      end else begin
         rd_data_o <= '0;
      end
   end
endmodule : word_store

// ---- core/port_phy_status_regs.sv ----
// Purpose: port link status, port-2 switch words and PHY special control
// Assumes: AHB-Lite single word transfers; PHY signals are asynchronous
// Notes:   every transfer takes one wait state; status irq clears on read

module port_phy_status_regs
   import phy_regs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic irq_o,
   input wire logic polarity_reversed_i,
   input wire logic rx_pause_active_i,
   input wire logic tx_pause_active_i,
   input wire logic speed_100_i,
   input wire logic full_duplex_i,
   input wire logic mdi_status_i,
   input wire logic an_done_i,
   input wire logic link_good_i,
   input wire logic [4:0] partner_abilities_i,
   input wire logic cable_done_i,
   input wire logic near_short_i,
   input wire logic [1:0] cable_result_i,
   input wire logic [8:0] fault_count_i,
   output logic cable_test_start_o,
   output logic crossover_algorithm_select_o,
   output logic force_link_pass_o,
   output logic power_save_disable_o,
   output logic near_end_loopback_o
);
   // ==========================================================
   // input synchronisers: two flops on every PHY-side bit
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   assign async_in = {cable_done_i, near_short_i, cable_result_i, fault_count_i,
                      partner_abilities_i, link_good_i, an_done_i, mdi_status_i,
                      full_duplex_i, speed_100_i, tx_pause_active_i,
                      rx_pause_active_i, polarity_reversed_i};
   for (genvar b = 0; b < SYNC_W; b++) begin : g_sync
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            sync1_r[b] <= 1'b0;
            sync2_r[b] <= 1'b0;
         end else begin
            sync1_r[b] <= async_in[b];
            sync2_r[b] <= sync1_r[b];
         end
      end
   end

   // named views of the synchronised bits
   wire [7:0] link_bits_s = sync2_r[7:0];
   wire [4:0] partner_s = sync2_r[12:8];
   wire [8:0] count_s = sync2_r[21:13];
   wire [1:0] result_s = sync2_r[23:22];
   wire short_s = sync2_r[24];
   wire done_s = sync2_r[25];

   // ==========================================================
   // bus front end
   bus_state_type state_r;
   bus_state_type state_nxt;
   logic [1:0] bank_r;
   logic [3:0] idx_r;
   logic write_r;
   logic valid_r;
   wire accept = hsel_i && htrans_i[1] && hready_i;
   wire addr_ok = (haddr_i[31:8] == 24'h00_0000) && (haddr_i[1:0] == 2'b00);
   wire data_phase = (state_r == BUS_WAIT);
   wire wr_now = data_phase && write_r && valid_r;
   wire rd_now = data_phase && !write_r && valid_r;

   // register selects in the data phase
   wire sel_link = (bank_r == BANK_PORT1) && (idx_r == IDX_P1_LINK_STATUS);
   wire sel_p2 = (bank_r == BANK_PORT2) && !idx_r[0] && (idx_r <= IDX_P2_EGRESS_RATE);
   wire sel_spec = (bank_r == BANK_PHY2) && (idx_r == IDX_P2_SPECIAL);
   wire sel_ists = (bank_r == BANK_IRQ) && (idx_r == IDX_IRQ_STATUS);
   wire sel_imsk = (bank_r == BANK_IRQ) && (idx_r == IDX_IRQ_MASK);
   wire [WORD_W-1:0] wdata = hwdata_i[WORD_W-1:0];

   // one wait state: a word store read needs the extra edge
   always_comb begin
      case (state_r)
         BUS_IDLE: state_nxt = accept ? BUS_WAIT : BUS_IDLE;
         BUS_WAIT: state_nxt = BUS_IDLE;
         default: state_nxt = BUS_IDLE;
      endcase
   end

   // address phase capture
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r <= BUS_IDLE;
         bank_r <= 2'h0;
         idx_r <= 4'h0;
         write_r <= 1'b0;
         valid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (accept && state_r == BUS_IDLE) begin
            bank_r <= haddr_i[BANK_LSB+:2];
            idx_r <= haddr_i[IDX_LSB+:4];
            write_r <= hwrite_i;
            valid_r <= addr_ok && (hsize_i == 3'h2);
         end
      end
   end

   // ==========================================================
   // port-2 switch control words
   logic [WORD_W-1:0] p2_rdata;
   word_store u_p2_words (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(wr_now && sel_p2),
      .wr_addr_i(idx_r[3:1]),
      .wr_data_i(wdata),
      .rd_addr_i(haddr_i[IDX_LSB+1+:MEM_AW]),
      .rd_data_o(p2_rdata)
   );

   // ==========================================================
   // control bits and cable diagnostic
   // one flop per duplicated bit feeds both the PHY pin and the read view
   logic xover_r;
   logic force_r;
   logic pwr_r;
   logic loop_r;
   logic diag_en_r;
   logic start_r;
   logic done_q_r;
   logic short_r;
   logic [1:0] result_r;
   logic [8:0] count_r;
   wire spec_wr = wr_now && sel_spec;
   wire diag_set = spec_wr && wdata[SP_DIAG_EN];
   wire done_rise = done_s && !done_q_r;
   wire diag_fin = done_rise && diag_en_r;

   // writable control fields
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         xover_r <= XOVER_RST;
         force_r <= 1'b0;
         pwr_r <= PWR_RST;
         loop_r <= 1'b0;
      end else begin
         if (wr_now && sel_link) begin
            xover_r <= wdata[LS_XOVER];
         end
         if (spec_wr) begin
            force_r <= wdata[SP_FORCE];
            pwr_r <= wdata[SP_PWR];
            loop_r <= wdata[SP_LOOP];
         end
      end
   end

   // enable bit: a start in the finishing cycle wins, writing 0 is ignored
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         diag_en_r <= 1'b0;
         start_r <= 1'b0;
         done_q_r <= 1'b0;
      end else begin
         done_q_r <= done_s;
         start_r <= diag_set;
         if (diag_set) begin
            diag_en_r <= 1'b1;
         end else if (diag_fin) begin
            diag_en_r <= 1'b0;
         end
      end
   end

   // results are frozen at completion, so a read is stable once enable clears
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         short_r <= 1'b0;
         result_r <= 2'b00;
         count_r <= 9'h000;
      end else if (diag_fin) begin
         short_r <= short_s;
         result_r <= result_s;
         count_r <= count_s;
      end
   end

   // ==========================================================
   // interrupt status and mask
   logic [IRQ_W-1:0] ists_r;
   logic [IRQ_W-1:0] imsk_r;
   logic [IRQ_W-1:0] ists_nxt;
   logic link_q_r;
   logic [1:0] mode_q_r;
   wire [IRQ_W-1:0] evt = {mode_q_r != link_bits_s[4:3], link_q_r != link_bits_s[7], diag_fin};
   wire [IRQ_W-1:0] ists_clr = (rd_now && sel_ists) ? '1 : '0;
   // new events win over the read clear
   assign ists_nxt = (ists_r & ~ists_clr) | evt;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ists_r <= '0;
         imsk_r <= IRQ_MASK_RST;
         link_q_r <= 1'b0;
         mode_q_r <= 2'b00;
         irq_o <= 1'b0;
      end else begin
         ists_r <= ists_nxt;
         link_q_r <= link_bits_s[7];
         mode_q_r <= link_bits_s[4:3];
         irq_o <= |(ists_r & imsk_r);
         if (wr_now && sel_imsk) begin
            imsk_r <= wdata[IRQ_W-1:0];
         end
      end
   end

   // ==========================================================
   // read data assembly
   logic [WORD_W-1:0] link_word;
   logic [WORD_W-1:0] spec_word;
   logic [WORD_W-1:0] rd_word;
   always_comb begin
      link_word = '0; // reserved bits 14 and 8 read zero
      link_word[LS_XOVER] = xover_r;
      link_word[LS_POL] = link_bits_s[0];
      link_word[LS_RXFC] = link_bits_s[1];
      link_word[LS_TXFC] = link_bits_s[2];
      link_word[LS_SPEED] = link_bits_s[3];
      link_word[LS_DUPLEX] = link_bits_s[4];
      link_word[LS_MDI] = link_bits_s[5];
      link_word[LS_AN_DONE] = link_bits_s[6];
      link_word[LS_LINK] = link_bits_s[7];
      link_word[LS_PARTNER_LSB+:5] = partner_s;
   end
   always_comb begin
      spec_word = '0;
      spec_word[SP_SHORT] = short_r;
      spec_word[SP_RESULT_LSB+:2] = result_r;
      spec_word[SP_DIAG_EN] = diag_en_r;
      spec_word[SP_FORCE] = force_r;
      spec_word[SP_PWR] = pwr_r;
      spec_word[SP_LOOP] = loop_r;
      spec_word[SP_COUNT_LSB+:9] = count_r;
   end
   assign rd_word = sel_link ? link_word :
                    sel_p2 ? p2_rdata :
                    sel_spec ? spec_word :
                    sel_ists ? {13'h0000, ists_r} :
                    sel_imsk ? {13'h0000, imsk_r} : 16'h0000;

   // ==========================================================
   // registered bus answer and control pins
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= !(accept && state_r == BUS_IDLE);
         hresp_o <= 1'b0;
         if (rd_now) begin
            hrdata_o <= {16'h0000, rd_word};
         end
      end
   end
   assign cable_test_start_o = start_r;
   assign crossover_algorithm_select_o = xover_r;
   assign force_link_pass_o = force_r;
   assign power_save_disable_o = pwr_r;
   assign near_end_loopback_o = loop_r;

   // ==========================================================
   // assertions
   wire rd_link = rd_now && sel_link;
   wire rd_spec = rd_now && sel_spec;

   xover_reset_a: assert property (@(posedge clock_i)
      $rose(rst_n_i) |-> crossover_algorithm_select_o && power_save_disable_o)
      else $error("crossover or power save reset value wrong");
   link_view_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_link |=> hrdata_o[13:9] == $past({link_bits_s[0], link_bits_s[1], link_bits_s[2],
                  link_bits_s[3], link_bits_s[4]}) && !hrdata_o[14])
      else $error("link status bits 13..9 mismatch");
   partner_view_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_link |=> hrdata_o[4:0] == $past(partner_s))
      else $error("partner ability bits mismatch");
   diag_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      diag_set |=> cable_test_start_o && diag_en_r ##1 !cable_test_start_o)
      else $error("cable test start not one pulse");
   diag_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      diag_fin && !diag_set |=> !diag_en_r)
      else $error("enable did not self clear");
   diag_result_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      diag_fin |=> {short_r, result_r, count_r} == $past({short_s, result_s, count_s}))
      else $error("cable results not captured at completion");
   force_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      spec_wr |=> {force_link_pass_o, power_save_disable_o, near_end_loopback_o}
                  == $past(wdata[SP_FORCE:SP_LOOP]))
      else $error("special control write lost");
   dup_view_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      rd_spec |=> hrdata_o[11:9] == $past({force_r, pwr_r, loop_r})
                  && hrdata_o[12] == $past(diag_en_r))
      else $error("control read view differs from pin");
   bus_wait_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      accept && state_r == BUS_IDLE |=> !hreadyout_o ##1 hreadyout_o)
      else $error("wait state length wrong");
   irq_level_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ##1 irq_o == $past(|(ists_r & imsk_r)))
      else $error("interrupt level wrong");

   diag_done_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      diag_set ##[1:1000] diag_fin);
   link_read_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) rd_link);
   irq_fire_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule : port_phy_status_regs

// ---- test/phy_model.sv ----
// Purpose: far-side PHY model that answers cable test starts
// Assumes: one clock shared with the register bank
// Notes:   results are held well around the done edge, then scrambled
module phy_model (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic slow_i,
   input wire logic [11:0] res_i,
   output logic cable_done_o,
   output logic [11:0] res_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // cable test sequencer
   int cnt;
   int lim;
   assign lim = slow_i ? 40 : 8;
   // results stand from the start pulse; done rises late and stays up 4 cycles
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt <= 0;
         cable_done_o <= 1'b0;
         res_o <= 12'h000;
      end else if (start_i) begin
         cnt <= 1;
         res_o <= res_i;
      end else if (cnt != 0) begin
         cnt <= cnt + 1;
         if (cnt == lim) cable_done_o <= 1'b1;
         if (cnt == lim + 4) cable_done_o <= 1'b0;
         // past the hold time the old result must not linger
         if (cnt == lim + 8) begin
            res_o <= ~res_o;
            cnt <= 0;
         end
      end
   end
endmodule : phy_model

// ---- test/port_phy_status_regs_test.sv ----
// Purpose: self-checking bench for the link status and cable test registers
// Assumes: AHB-Lite single word transfers, one wait state
// Notes:   random stimulus from a fixed seed plus corner values
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module port_phy_status_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals
   logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, slow = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd, wd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [12:0] lv = 0;
   logic [11:0] res = 0;
   logic [15:0] pw [6];
   logic [2:0] ctrl;
   logic msk;
   wire [31:0] hrdata;
   wire [11:0] cres;
   wire hready, hresp, irq, start, xov, force_l, pwr, loopb, done;
   int seed = 32'h29d6_46c8;
   int mismatches = 0, cmp_count = 0, cycles = 0, starts = 0, i, n;
   port_phy_status_regs port_phy_status_regs_inst (.clock_i(clock), .rst_n_i(rst_n),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .irq_o(irq), .polarity_reversed_i(lv[12]), .rx_pause_active_i(lv[11]),
      .tx_pause_active_i(lv[10]), .speed_100_i(lv[9]), .full_duplex_i(lv[8]),
      .mdi_status_i(lv[7]), .an_done_i(lv[6]), .link_good_i(lv[5]),
      .partner_abilities_i(lv[4:0]), .cable_done_i(done), .near_short_i(cres[11]),
      .cable_result_i(cres[10:9]), .fault_count_i(cres[8:0]), .cable_test_start_o(start),
      .crossover_algorithm_select_o(xov), .force_link_pass_o(force_l),
      .power_save_disable_o(pwr), .near_end_loopback_o(loopb));
   phy_model phy_model_inst (.clock_i(clock), .rst_n_i(rst_n), .start_i(start),
      .slow_i(slow), .res_i(res), .cable_done_o(done), .res_o(cres));
   // ==========================================================
   // clock, timeout and start pulse count
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (start === 1'b1) starts++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // ==========================================================
   // expectation helpers
   function automatic logic [15:0] link_word(input logic x, input logic [12:0] v);
      return {x, 1'b0, v[12:8], 1'b0, v[7:0]};
   endfunction : link_word
   function automatic logic [15:0] diag_word(input logic [11:0] r, input logic [2:0] c);
      return {r[11:9], 1'b0, c, r[8:0]};
   endfunction : diag_word
   // one single transfer; entered just after a rising edge, waits on hready
   task automatic bus_xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      k = 0;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 50);
      htrans <= 2'b00;
      hwdata <= d;
      k = 0;
      do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 50);
      r = hrdata;
   endtask : bus_xfer
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      // reset values
      bus_xfer(32'h0000_0010, 1'b0, 32'h0000_0000, rd);
      `CHK(rd[15:0], 16'h8000)
      bus_xfer(32'h0000_0080, 1'b0, 32'h0000_0000, rd);
      `CHK(rd[15:0], 16'h0400)
      `CHK({xov, pwr, force_l, loopb}, 4'h0c)
      bus_xfer(32'h0000_00c4, 1'b0, 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0000)
      // link status view, corners first; read-only bits ignore writes
      for (i = 0; i < 8; i++) begin
         lv <= (i == 0) ? 13'h1fff : (i == 1) ? 13'h0000 : 13'($random(seed));
         wd = $random(seed);
         bus_xfer(32'h0000_0010, 1'b1, wd, rd);
         repeat (4) @(posedge clock);
         bus_xfer(32'h0000_0010, 1'b0, 32'h0000_0000, rd);
         `CHK(rd[15:0], link_word(wd[15], lv))
         `CHK(xov, wd[15])
      end
      // port-2 switch words, odd index unmapped
      for (i = 0; i < 6; i++) begin
         pw[i] = 16'($random(seed));
         bus_xfer(32'h0000_0040 + 8 * i, 1'b1, {16'h0000, pw[i]}, rd);
      end
      bus_xfer(32'h0000_0044, 1'b1, 32'h0000_ffff, rd);
      bus_xfer(32'h0000_0044, 1'b0, 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0000)
      for (i = 0; i < 6; i++) begin
         bus_xfer(32'h0000_0040 + 8 * i, 1'b0, 32'h0000_0000, rd);
         `CHK(rd, {16'h0000, pw[i]})
      end
      bus_xfer(32'h0000_00c0, 1'b0, 32'h0000_0000, rd);
      // cable test, every result code, fast and slow, irq masked and unmasked
      for (i = 0; i < 4; i++) begin
         slow <= i[1];
         res <= {1'($random(seed)), i[1:0], 9'($random(seed))};
         msk = i[0];
         bus_xfer(32'h0000_00c4, 1'b1, {31'h0, msk}, rd);
         ctrl = 3'($random(seed));
         wd = ($random(seed) & 32'h0000_e1ff) | 32'h0000_1000 | (32'(ctrl) << 9);
         bus_xfer(32'h0000_0080, 1'b1, wd, rd);
         `CHK({force_l, pwr, loopb}, ctrl)
         bus_xfer(32'h0000_0080, 1'b0, 32'h0000_0000, rd);
         `CHK(rd[12], 1'b1)
         n = 0;
         // software polls until the enable bit drops before trusting results
         while (rd[12] === 1'b1 && n < 60) begin
            bus_xfer(32'h0000_0080, 1'b0, 32'h0000_0000, rd);
            n++;
         end
         `CHK(rd[15:0], diag_word(res, ctrl))
         repeat (2) @(posedge clock);
         `CHK(irq, msk)
         bus_xfer(32'h0000_00c0, 1'b0, 32'h0000_0000, rd);
         `CHK(rd[0], 1'b1)
         repeat (2) @(posedge clock);
         `CHK(irq, 1'b0)
      end
      // refused transfers: non-word size and high address bits leave the mask alone
      hsize <= 3'h1;
      bus_xfer(32'h0000_00c4, 1'b1, 32'h0000_0007, rd);
      hsize <= 3'h2;
      bus_xfer(32'h0000_01c4, 1'b1, 32'h0000_0007, rd);
      bus_xfer(32'h0000_00c4, 1'b0, 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0001)
      `CHK(hresp, 1'b0)
      // link and speed changes set their own status bits
      bus_xfer(32'h0000_00c4, 1'b1, 32'h0000_0006, rd);
      lv <= lv ^ 13'h0220;
      repeat (6) @(posedge clock);
      `CHK(irq, 1'b1)
      bus_xfer(32'h0000_00c0, 1'b0, 32'h0000_0000, rd);
      `CHK(rd, 32'h0000_0006)
      repeat (2) @(posedge clock);
      `CHK(irq, 1'b0)
      // writing zero to the enable must not start a test
      bus_xfer(32'h0000_0080, 1'b1, 32'h0000_0400, rd);
      repeat (2) @(posedge clock);
      `CHK(starts, 4)
      complete_run();
   end
endmodule : port_phy_status_regs_test
